// *** hdl/rro_rotate_core.sv ***
// Purpose: rotate instruction executor with file memory behind axi4-lite
// Assumes: one master, one write and one read outstanding at a time
// Notes:   a write to the instruction register while idle starts one four-quarter cycle
`include "rro_consts.svh"
module rro_rotate_core (
  input  wire logic                   aclk,           // core clock, 200 mhz
  input  wire logic                   aresetn,        // synchronous reset, active low
  input  wire logic [`RRO_AXI_AW-1:0] s_axi_awaddr,   // write address
  input  wire logic                   s_axi_awvalid,  // write address valid
  output logic                        s_axi_awready,  // write address ready
  input  wire logic [`RRO_AXI_DW-1:0] s_axi_wdata,    // write data
  input  wire logic [`RRO_STRB_W-1:0] s_axi_wstrb,    // write byte strobes
  input  wire logic                   s_axi_wvalid,   // write data valid
  output logic                        s_axi_wready,   // write data ready
  output logic [1:0]                  s_axi_bresp,    // write response
  output logic                        s_axi_bvalid,   // write response valid
  input  wire logic                   s_axi_bready,   // write response ready
  input  wire logic [`RRO_AXI_AW-1:0] s_axi_araddr,   // read address
  input  wire logic                   s_axi_arvalid,  // read address valid
  output logic                        s_axi_arready,  // read address ready
  output logic [`RRO_AXI_DW-1:0]      s_axi_rdata,    // read data
  output logic [1:0]                  s_axi_rresp,    // read response
  output logic                        s_axi_rvalid,   // read data valid
  input  wire logic                   s_axi_rready    // read data ready
);
  rro_pkg::rro_phase_type     phase;                     // quarter sequencer
  rro_pkg::rro_instr_type     instr;                     // latched instruction word
  rro_pkg::rro_op_type        op_q;                      // decoded operation
  rro_pkg::rro_result_type    rot_res;                   // combinational rotate output
  rro_pkg::rro_result_type    res_q;                     // registered result
  logic [`RRO_MEM_AW-1:0]     eff_addr;                  // operand address now
  logic [`RRO_MEM_AW-1:0]     eff_addr_q;                // operand address held
  logic [`RRO_BYTE_W-1:0]     operand_q;                 // operand read in q2
  logic [`RRO_BYTE_W-1:0]     wreg;                      // working accumulator
  logic                       flag_c;                    // carry flag
  logic                       flag_z;                    // zero flag
  logic                       flag_n;                    // negative flag
  logic                       ill_op;                    // sticky unknown opcode flag
  logic [`RRO_BANK_W-1:0]     bank_select_register;      // bank for a=1 accesses
  logic [`RRO_MEM_AW-1:0]     faddr;                     // software file pointer
  logic [`RRO_BYTE_W-1:0]     mem [0:`RRO_MEM_DEPTH-1];  // data file
  logic                       have_aw;                   // write address held
  logic                       have_w;                    // write data held
  logic [`RRO_AXI_AW-1:0]     aw_addr_q;                 // held write address
  logic [`RRO_AXI_DW-1:0]     wdata_q;                   // held write data
  logic [`RRO_STRB_W-1:0]     wstrb_q;                   // held strobes
  logic                       busy;                      // instruction in flight
  logic                       wr_fire;                   // write performed this cycle
  logic                       wr_ok;                     // write accepted into a register
  logic                       start;                     // instruction launch pulse
  rro_pkg::rro_reg_type       wr_sel;                    // register addressed by the write
  logic [`RRO_AXI_DW-1:0]     wr_merged;                 // old value merged with strobed bytes

  // map a bus address onto a register
  function automatic rro_pkg::rro_reg_type reg_decode(input logic [`RRO_AXI_AW-1:0] addr);
    unique case (addr[`RRO_AXI_AW-1:`RRO_WORD_LSB])
      `RRO_IDX_INSTR:  reg_decode = rro_pkg::REG_INSTR;
      `RRO_IDX_WREG:   reg_decode = rro_pkg::REG_WREG;
      `RRO_IDX_STATUS: reg_decode = rro_pkg::REG_STATUS;
      `RRO_IDX_BANK:   reg_decode = rro_pkg::REG_BANK;
      `RRO_IDX_FADDR:  reg_decode = rro_pkg::REG_FADDR;
      `RRO_IDX_FDATA:  reg_decode = rro_pkg::REG_FDATA;
      default:         reg_decode = rro_pkg::REG_NONE;
    endcase
  endfunction

  // current contents of a register as a bus word
  function automatic logic [`RRO_AXI_DW-1:0] reg_view(input rro_pkg::rro_reg_type sel);
    reg_view = '0;
    unique case (sel)
      rro_pkg::REG_INSTR:  reg_view[`RRO_INSTR_W-1:0] = instr;
      rro_pkg::REG_WREG:   reg_view[`RRO_BYTE_W-1:0]  = wreg;
      rro_pkg::REG_STATUS: begin
        reg_view[`RRO_ST_C]    = flag_c;
        reg_view[`RRO_ST_Z]    = flag_z;
        reg_view[`RRO_ST_N]    = flag_n;
        reg_view[`RRO_ST_BUSY] = busy;
        reg_view[`RRO_ST_ILL]  = ill_op;
      end
      rro_pkg::REG_BANK:   reg_view[`RRO_BANK_W-1:0]  = bank_select_register;
      rro_pkg::REG_FADDR:  reg_view[`RRO_MEM_AW-1:0]  = faddr;
      rro_pkg::REG_FDATA:  reg_view[`RRO_BYTE_W-1:0]  = mem[faddr];
      rro_pkg::REG_NONE:   reg_view = '0;
    endcase
  endfunction

  // replace only the byte lanes whose strobe is set
  function automatic logic [`RRO_AXI_DW-1:0] merge_bytes(input logic [`RRO_AXI_DW-1:0] old_w,
                                                         input logic [`RRO_AXI_DW-1:0] new_w,
                                                         input logic [`RRO_STRB_W-1:0] strb);
    merge_bytes = old_w;
    for (int i = 0; i < `RRO_STRB_W; i++) begin
      if (strb[i]) begin
        merge_bytes[i*`RRO_BYTE_W +: `RRO_BYTE_W] = new_w[i*`RRO_BYTE_W +: `RRO_BYTE_W];
      end
    end
  endfunction

  // opcode recogniser on the upper instruction bits
  function automatic rro_pkg::rro_op_type decode_op(input logic [`RRO_OPC_W-1:0] opc);
    if (opc == `RRO_OPC_ROT_LEFT) begin
      decode_op = rro_pkg::ROT_LEFT;
    end else if (opc == `RRO_OPC_ROT_RIGHT) begin
      decode_op = rro_pkg::ROT_RIGHT_C;
    end else begin
      decode_op = rro_pkg::ROT_NONE;
    end
  endfunction

  // bus handshake and write qualification
  assign s_axi_awready = !have_aw;
  assign s_axi_wready  = !have_w;
  assign s_axi_arready = !s_axi_rvalid;
  assign busy          = (phase != rro_pkg::PH_IDLE);
  assign wr_fire       = have_aw && have_w && !s_axi_bvalid;
  assign wr_sel        = reg_decode(aw_addr_q);
  assign wr_ok         = wr_fire && (wr_sel != rro_pkg::REG_NONE) && !busy;
  assign start         = wr_ok && (wr_sel == rro_pkg::REG_INSTR);

  // old register value with the strobed lanes replaced; a process so that it
  // follows every register the view function reads, not only its arguments
  always_comb begin
    wr_merged = merge_bytes(reg_view(wr_sel), wdata_q, wstrb_q);
  end

  // operand address: access region or bank plus field
  always_comb begin
    if (!instr.access) begin
      if (instr.faddr < `RRO_ACCESS_SPLIT) begin
        eff_addr = {`RRO_ACCESS_LO, instr.faddr};
      end else begin
        eff_addr = {`RRO_ACCESS_HI, instr.faddr};
      end
    end else begin
      eff_addr = {bank_select_register, instr.faddr};
    end
  end

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw   <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && !have_aw) begin
      have_aw   <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      have_aw   <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_w  <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && !have_w) begin
      have_w  <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      have_w  <= 1'b0;
    end
  end

  // write response: refused when busy or unmapped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RRO_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `RRO_RESP_OKAY : `RRO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `RRO_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= reg_view(reg_decode(s_axi_araddr));
      s_axi_rresp  <= (reg_decode(s_axi_araddr) == rro_pkg::REG_NONE) ? `RRO_RESP_SLVERR : `RRO_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // quarter sequencer: one instruction cycle of four clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= rro_pkg::PH_IDLE;
    end else begin
      unique case (phase)
        rro_pkg::PH_IDLE: if (start) phase <= rro_pkg::PH_Q1;
        rro_pkg::PH_Q1:   phase <= rro_pkg::PH_Q2;
        rro_pkg::PH_Q2:   phase <= rro_pkg::PH_Q3;
        rro_pkg::PH_Q3:   phase <= rro_pkg::PH_Q4;
        rro_pkg::PH_Q4:   phase <= rro_pkg::PH_IDLE;
      endcase
    end
  end

  // instruction word latch and q1 decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr <= `RRO_RST_INSTR;
      op_q  <= rro_pkg::ROT_NONE;
    end else begin
      if (start) begin
        instr <= rro_pkg::rro_instr_type'(wr_merged[`RRO_INSTR_W-1:0]);
      end
      if (phase == rro_pkg::PH_Q1) begin
        op_q <= decode_op(instr.opcode);
      end
    end
  end

  // sticky unknown opcode flag, set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ill_op <= 1'b0;
    end else if (phase == rro_pkg::PH_Q1 && decode_op(instr.opcode) == rro_pkg::ROT_NONE) begin
      ill_op <= 1'b1;
    end else if (wr_ok && wr_sel == rro_pkg::REG_STATUS && wstrb_q[`RRO_ST_ILL/`RRO_BYTE_W] &&
                 wdata_q[`RRO_ST_ILL]) begin
      ill_op <= 1'b0;
    end
  end

  // q2 read of the operand, q3 compute
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand_q  <= `RRO_RST_BYTE;
      eff_addr_q <= '0;
      res_q      <= '0;
    end else begin
      if (phase == rro_pkg::PH_Q2) begin
        operand_q  <= mem[eff_addr];
        eff_addr_q <= eff_addr;
      end
      if (phase == rro_pkg::PH_Q3) begin
        res_q <= rot_res;
      end
    end
  end

  rro_rotate_unit u_rotate (
    .op       (op_q),
    .operand  (operand_q),
    .carry_in (flag_c),
    .result   (rot_res)
  );

  // accumulator: q4 result when d is zero, else software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wreg <= `RRO_RST_BYTE;
    end else if (phase == rro_pkg::PH_Q4 && op_q != rro_pkg::ROT_NONE && !instr.dest) begin
      wreg <= res_q.value;
    end else if (wr_ok && wr_sel == rro_pkg::REG_WREG) begin
      wreg <= wr_merged[`RRO_BYTE_W-1:0];
    end
  end

  // status flags: n and z on both rotates, carry on the right rotate only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_c <= 1'b0;
      flag_z <= 1'b0;
      flag_n <= 1'b0;
    end else if (phase == rro_pkg::PH_Q4 && op_q != rro_pkg::ROT_NONE) begin
      flag_z <= res_q.zero;
      flag_n <= res_q.negative;
      if (op_q == rro_pkg::ROT_RIGHT_C) begin
        flag_c <= res_q.carry;
      end
    end else if (wr_ok && wr_sel == rro_pkg::REG_STATUS) begin
      flag_c <= wr_merged[`RRO_ST_C];
      flag_z <= wr_merged[`RRO_ST_Z];
      flag_n <= wr_merged[`RRO_ST_N];
    end
  end

  // bank select and software file pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_select_register <= `RRO_RST_BANK;
      faddr                <= `RRO_RST_FADDR;
    end else if (wr_ok && wr_sel == rro_pkg::REG_BANK) begin
      bank_select_register <= wr_merged[`RRO_BANK_W-1:0];
    end else if (wr_ok && wr_sel == rro_pkg::REG_FADDR) begin
      faddr <= wr_merged[`RRO_MEM_AW-1:0];
    end
  end

  // data file: q4 write-back when d is one, else software
  always_ff @(posedge aclk) begin
    if (phase == rro_pkg::PH_Q4 && op_q != rro_pkg::ROT_NONE && instr.dest) begin
      mem[eff_addr_q] <= res_q.value;
    end else if (wr_ok && wr_sel == rro_pkg::REG_FDATA) begin
      mem[faddr] <= wr_merged[`RRO_BYTE_W-1:0];
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [`RRO_BYTE_W-1:0] mem_at_op;  // file byte at the held operand address
  assign mem_at_op = mem[eff_addr_q];

  sequence s_quarters;
    phase == rro_pkg::PH_Q1 ##1 phase == rro_pkg::PH_Q2 ##1 phase == rro_pkg::PH_Q3 ##1 phase == rro_pkg::PH_Q4;
  endsequence
  sequence s_compute(rro_pkg::rro_op_type o);
    phase == rro_pkg::PH_Q3 && op_q == o;
  endsequence

  AST_LEFT_VALUE: assert property (s_compute(rro_pkg::ROT_LEFT) |=>
    res_q.value == {$past(operand_q[`RRO_BYTE_MSB-1:`RRO_BYTE_LSB]), $past(operand_q[`RRO_BYTE_MSB])})
    else $error("left rotate value wrong");
  AST_LEFT_CARRY_KEPT: assert property (s_compute(rro_pkg::ROT_LEFT) |=> ##1 $stable(flag_c))
    else $error("left rotate changed carry");
  AST_RIGHT_VALUE: assert property (s_compute(rro_pkg::ROT_RIGHT_C) |=>
    res_q.value == {$past(flag_c), $past(operand_q[`RRO_BYTE_MSB:`RRO_BYTE_LSB+1])})
    else $error("right rotate value wrong");
  AST_RIGHT_CARRY: assert property (s_compute(rro_pkg::ROT_RIGHT_C) |=> ##1
    flag_c == $past(operand_q[`RRO_BYTE_LSB], 2) && flag_n == $past(flag_c, 2))
    else $error("right rotate carry or top bit wrong");
  AST_DEST_ACC: assert property (phase == rro_pkg::PH_Q4 && op_q != rro_pkg::ROT_NONE && !instr.dest
    |=> wreg == $past(res_q.value) && mem_at_op == $past(mem_at_op))
    else $error("accumulator destination wrong");
  AST_DEST_FILE: assert property (phase == rro_pkg::PH_Q4 && op_q != rro_pkg::ROT_NONE && instr.dest
    |=> mem_at_op == $past(res_q.value) && $stable(wreg))
    else $error("file destination wrong");
  AST_ACCESS_REGION: assert property (phase == rro_pkg::PH_Q2 && !instr.access
    |-> eff_addr[`RRO_MEM_AW-1:`RRO_BYTE_W] == ((instr.faddr < `RRO_ACCESS_SPLIT) ? `RRO_ACCESS_LO : `RRO_ACCESS_HI))
    else $error("access region address wrong");
  AST_BANKED: assert property (phase == rro_pkg::PH_Q2 && instr.access
    |=> eff_addr_q == {$past(bank_select_register), $past(instr.faddr)})
    else $error("banked address wrong");
  AST_ONE_CYCLE: assert property (start |=> s_quarters ##1 phase == rro_pkg::PH_IDLE)
    else $error("instruction did not take four quarters");
  AST_DECODE: assert property (phase == rro_pkg::PH_Q1 && instr.opcode == `RRO_OPC_ROT_RIGHT
    |=> op_q == rro_pkg::ROT_RIGHT_C)
    else $error("right rotate not decoded");
endmodule // rro_rotate_core

// *** hdl/rro_consts.svh ***
// Purpose: shared constants for the rotate instruction datapath
// Assumes: 32-bit axi4-lite register access, one aclk domain
// Notes:   included by the package and by every design module
//
// Functional notes
// - left rotate shifts operand left one place
// - left rotate: bit7 to bit0, flags N,Z only
// - right rotate through carry as ninth bit
// - right rotate: bit0 to C, C to bit7
// - destination zero writes accumulator, file unchanged
// - destination one writes back to file register
// - access zero uses fixed access region only
// - access one combines bank select with field
// - one word, four quarters: decode, read, compute, write
`ifndef RRO_CONSTS_SVH
`define RRO_CONSTS_SVH

// data and address widths
`define RRO_BYTE_W        8
`define RRO_BYTE_MSB      7
`define RRO_BYTE_LSB      0
`define RRO_INSTR_W       16
`define RRO_OPC_W         6
`define RRO_BANK_W        4
`define RRO_MEM_AW        12
`define RRO_MEM_DEPTH     4096
`define RRO_AXI_AW        6
`define RRO_AXI_DW        32
`define RRO_STRB_W        4
`define RRO_WORD_LSB      2

// opcode patterns in the upper six instruction bits
`define RRO_OPC_ROT_LEFT  6'h11
`define RRO_OPC_ROT_RIGHT 6'h0c

// fixed access region: low half maps to bank 0, high half to the top bank
`define RRO_ACCESS_SPLIT  8'h80
`define RRO_ACCESS_LO     4'h0
`define RRO_ACCESS_HI     4'hf

// register word indices (byte address is index times four)
`define RRO_IDX_INSTR     4'h0
`define RRO_IDX_WREG      4'h1
`define RRO_IDX_STATUS    4'h2
`define RRO_IDX_BANK      4'h3
`define RRO_IDX_FADDR     4'h4
`define RRO_IDX_FDATA     4'h5

// status register bit positions
`define RRO_ST_C          0
`define RRO_ST_Z          1
`define RRO_ST_N          2
`define RRO_ST_BUSY       8
`define RRO_ST_ILL        9

// reset values
`define RRO_RST_BYTE      8'h00
`define RRO_RST_BANK      4'h0
`define RRO_RST_FADDR     12'h000
`define RRO_RST_INSTR     16'h0000

// axi responses
`define RRO_RESP_OKAY     2'h0
`define RRO_RESP_SLVERR   2'h2

`endif

// *** hdl/rro_pkg.sv ***
// Purpose: types shared by the rotate datapath modules
// Assumes: rro_consts.svh gives all struct field widths
// Notes:   types only, no constants of its own
`include "rro_consts.svh"
package rro_pkg;
  // operation chosen by the decoder
  typedef enum logic [1:0] {ROT_NONE, ROT_LEFT, ROT_RIGHT_C} rro_op_type;
  // quarter phase sequencer states
  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} rro_phase_type;
  // register selected by a bus address
  typedef enum logic [2:0] {REG_INSTR, REG_WREG, REG_STATUS, REG_BANK, REG_FADDR, REG_FDATA,
                            REG_NONE} rro_reg_type;
  // one instruction word
  typedef struct packed {
    logic [`RRO_OPC_W-1:0]  opcode;
    logic                   dest;
    logic                   access;
    logic [`RRO_BYTE_W-1:0] faddr;
  } rro_instr_type;
  // rotate outcome with flags
  typedef struct packed {
    logic [`RRO_BYTE_W-1:0] value;
    logic                   carry;
    logic                   negative;
    logic                   zero;
  } rro_result_type;
endpackage : rro_pkg

// *** hdl/rro_rotate_unit.sv ***
// Purpose: combinational rotate and flag generation
// Assumes: operand and carry are stable during the compute quarter
// Notes:   no storage; the core registers the result
`include "rro_consts.svh"
module rro_rotate_unit (
  input  wire rro_pkg::rro_op_type     op,        // operation to perform
  input  wire logic [`RRO_BYTE_W-1:0]  operand,   // byte read from the file
  input  wire logic                    carry_in,  // current carry flag
  output rro_pkg::rro_result_type      result     // rotated byte and flags
);
  // rotate and derive negative and zero from the new byte
  always_comb begin
    result       = '0;
    result.carry = carry_in;
    unique case (op)
      rro_pkg::ROT_LEFT: begin
        // shift left, old top bit wraps round, carry kept
        result.value = {operand[`RRO_BYTE_MSB-1:`RRO_BYTE_LSB], operand[`RRO_BYTE_MSB]};
      end
      rro_pkg::ROT_RIGHT_C: begin
        // nine-bit rotate: carry enters the top, bottom bit leaves to carry
        result.value = {carry_in, operand[`RRO_BYTE_MSB:`RRO_BYTE_LSB+1]};
        result.carry = operand[`RRO_BYTE_LSB];
      end
      rro_pkg::ROT_NONE: begin
        // pass through, nothing is written for this case
        result.value = operand;
      end
    endcase
    result.negative = result.value[`RRO_BYTE_MSB];
    result.zero     = (result.value == `RRO_RST_BYTE);
  end
endmodule // rro_rotate_unit

// *** dv/rro_rotate_core_tb.sv ***
// Purpose: self-checking bench for the rotate instruction core
// Assumes: register map and timing of the core hand-over contract
// Notes:   axi4-lite driven directly by tasks, no partner model
`include "rro_consts.svh"
module rro_rotate_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;                     // 200 mhz core clock
  logic        aresetn;                         // synchronous reset, active low
  logic [5:0]  awaddr, araddr;                  // write and read addresses
  logic [31:0] wdata, rdata;                    // write and read data
  logic [3:0]  wstrb;                           // byte lanes
  logic [1:0]  bresp, rresp;                    // responses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          failures, checks;                // verdict counters
  localparam logic [5:0] a_instr = {`RRO_IDX_INSTR, 2'b00};
  localparam logic [5:0] a_wreg  = {`RRO_IDX_WREG, 2'b00};
  localparam logic [5:0] a_stat  = {`RRO_IDX_STATUS, 2'b00};
  localparam logic [5:0] a_bank  = {`RRO_IDX_BANK, 2'b00};
  localparam logic [5:0] a_faddr = {`RRO_IDX_FADDR, 2'b00};
  localparam logic [5:0] a_fdata = {`RRO_IDX_FDATA, 2'b00};
  localparam logic [1:0] ok = `RRO_RESP_OKAY;
  localparam logic [1:0] err = `RRO_RESP_SLVERR;

  rro_rotate_core u_rro_rotate_core (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // free-running clock, 5 ns period
  always #2.5 aclk = ~aclk;

  // one counted comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  // verdict and end of run
  task automatic print_verdict();
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a wait that ran out counts as a mismatch
  task automatic give_up();
    failures++;
    $display("MISMATCH handshake expected answer seen none");
    print_verdict();
  endtask
  // write one word, both channels offered together, response checked
  task automatic wr(input logic [5:0] addr, input logic [31:0] data, input logic [1:0] exp);
    int n;
    @(posedge aclk);
    awaddr <= addr;
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 50) give_up();
    bready <= 1'b0;
    chk("bresp", {30'h0, exp}, {30'h0, bresp});
  endtask
  // read one word, response checked
  task automatic rd(input logic [5:0] addr, input logic [1:0] exp, output logic [31:0] data);
    int n;
    @(posedge aclk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 50) give_up();
    data = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, exp}, {30'h0, rresp});
  endtask
  // read a register and compare
  task automatic reg_is(input logic [5:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    rd(addr, ok, d);
    chk("register", exp, d);
  endtask
  // load and inspect one file byte
  task automatic put_file(input logic [11:0] fa, input logic [7:0] v);
    wr(a_faddr, {20'h0, fa}, ok);
    wr(a_fdata, {24'h0, v}, ok);
  endtask
  task automatic file_is(input logic [11:0] fa, input logic [7:0] v);
    wr(a_faddr, {20'h0, fa}, ok);
    reg_is(a_fdata, {24'h0, v});
  endtask
  // start an instruction word
  task automatic issue(input logic [5:0] opc, input logic d, input logic a, input logic [7:0] f);
    wr(a_instr, {16'h0, opc, d, a, f}, ok);
  endtask
  // poll until busy drops, bounded
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    for (n = 0; n < 20; n++) begin
      rd(a_stat, ok, s);
      if (s[`RRO_ST_BUSY] === 1'b0) break;
    end
    if (n == 20) give_up();
  endtask

  // bench watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    give_up();
  end

  // main sequence
  initial begin
    logic [31:0] d;
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    reg_is(a_stat, 32'h0);
    // left rotate into the file, carry preset and kept, write while busy refused
    wr(a_stat, 32'h1, ok);
    put_file(12'h010, 8'hab);
    issue(`RRO_OPC_ROT_LEFT, 1'b1, 1'b0, 8'h10);
    wr(a_wreg, 32'hff, err);
    wait_idle();
    file_is(12'h010, 8'h57);
    reg_is(a_wreg, 32'h0);
    reg_is(a_stat, 32'h1);
    // right rotate through a clear carry into the accumulator
    wr(a_stat, 32'h0, ok);
    put_file(12'h010, 8'he6);
    issue(`RRO_OPC_ROT_RIGHT, 1'b0, 1'b0, 8'h10);
    wait_idle();
    reg_is(a_wreg, 32'h73);
    file_is(12'h010, 8'he6);
    reg_is(a_stat, 32'h0);
    // banked operand, carry in to bit 7 and bit 0 out to carry
    wr(a_stat, 32'h1, ok);
    wr(a_bank, 32'h5, ok);
    put_file(12'h520, 8'h01);
    put_file(12'h020, 8'h55);
    issue(`RRO_OPC_ROT_RIGHT, 1'b1, 1'b1, 8'h20);
    wait_idle();
    file_is(12'h520, 8'h80);
    file_is(12'h020, 8'h55);
    reg_is(a_stat, 32'h5);
    // upper access half ignores the bank, zero result sets zero flag
    put_file(12'hf90, 8'h00);
    put_file(12'h590, 8'h33);
    wr(a_wreg, 32'haa, ok);
    issue(`RRO_OPC_ROT_LEFT, 1'b0, 1'b0, 8'h90);
    wait_idle();
    reg_is(a_wreg, 32'h0);
    file_is(12'h590, 8'h33);
    reg_is(a_stat, 32'h3);
    // unknown opcode writes nothing and flags illegal
    wr(a_wreg, 32'h5a, ok);
    issue(6'h3f, 1'b0, 1'b0, 8'h90);
    wait_idle();
    reg_is(a_wreg, 32'h5a);
    reg_is(a_stat, 32'h203);
    // a write whose strobes miss the accumulator lane leaves it as it was
    wstrb <= 4'h2;
    wr(a_wreg, 32'h11, ok);
    wstrb <= 4'hf;
    reg_is(a_wreg, 32'h5a);
    wr(a_stat, 32'h200, ok);
    reg_is(a_stat, 32'h0);
    // unmapped address refused both ways
    wr(6'h3c, 32'h1, err);
    rd(6'h3c, err, d);
    chk("unmapped", 32'h0, d);
    print_verdict();
  end
endmodule // rro_rotate_core_tb
